// file: src/spwf_pkg.sv
// Constants shared by the serial port word framing block.
// Assumes a 14-bit data memory address space reaching the port registers.
package spwf_pkg;

  // Register addresses of both port instances
  localparam logic [13:0] SPWF_P1_DIV_ADDR = 14'h3ff0;
  localparam logic [13:0] SPWF_P1_CTL_ADDR = 14'h3ff2;
  localparam logic [13:0] SPWF_P0_DIV_ADDR = 14'h3ff4;
  localparam logic [13:0] SPWF_P0_CTL_ADDR = 14'h3ff6;

  // Control register field positions
  localparam int SPWF_LEN_LSB      = 0;
  localparam int SPWF_LEN_MSB      = 3;
  localparam int SPWF_RX_POL_BIT   = 6;
  localparam int SPWF_TX_POL_BIT   = 7;
  localparam int SPWF_RX_INT_BIT   = 8;
  localparam int SPWF_TX_INT_BIT   = 9;
  localparam int SPWF_TX_ALT_BIT   = 10;
  localparam int SPWF_TX_REQ_BIT   = 11;
  localparam int SPWF_RX_ALT_BIT   = 12;
  localparam int SPWF_RX_REQ_BIT   = 13;
  localparam int SPWF_SCLK_INT_BIT = 14;

  // Reset values
  localparam logic [15:0] SPWF_CTL_RST  = 16'h0000;
  localparam logic [15:0] SPWF_DIV_RST  = 16'h0000;
  localparam logic [15:0] SPWF_DATA_RST = 16'h0000;

  // Internal serial clock half period in core cycles
  localparam int SPWF_SCLK_HALF_DEF = 4;

  // Word sequencer state
  typedef enum logic [0:0] {
    SPWF_IDLE = 1'b0,
    SPWF_BUSY = 1'b1
  } spwf_word_st_t;

endpackage

// file: src/spwf_sync2.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clk_in and change slowly against it.
`timescale 1ns/1ps
`default_nettype none
module spwf_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // spwf_sync2
`default_nettype wire

// file: src/spwf_frame_ctl.sv
// Word sequencer of one direction: frame check, bit count, word start/end.
// Assumes fall_in is a one-cycle pulse per serial clock falling edge.
`timescale 1ns/1ps
`default_nettype none
module spwf_frame_ctl
  import spwf_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  // Framing inputs
  input  wire logic       fall_in,
  input  wire logic       frame_in,
  input  wire logic       alt_in,
  input  wire logic       req_in,
  input  wire logic [3:0] len_m1_in,
  // Sequencer view
  output logic            bit_out,
  output logic [3:0]      idx_out,
  output logic            last_out,
  output logic            wstart_out,
  output logic            busy_out,
  output logic [3:0]      cnt_out
);

  spwf_word_st_t st_r;
  logic [3:0]    cnt_r;
  logic          started_r;
  logic          idle;
  logic          chk;
  logic          want;

  // Alternate checks only between words, normal also on the last bit
  always_comb begin
    idle       = (st_r == SPWF_IDLE);
    chk        = alt_in ? idle : (idle || (cnt_r == len_m1_in));
    // Unframed: first sync starts, later words run on without one
    want       = (frame_in && (req_in || !started_r)) || (started_r && !req_in);
    wstart_out = chk && want;
    bit_out    = alt_in ? (!idle || wstart_out) : !idle;
    idx_out    = (alt_in && idle) ? 4'h0 : cnt_r;
    last_out   = bit_out && (idx_out == len_m1_in);
    busy_out   = !idle;
    cnt_out    = cnt_r;
  end

  // Frame is not looked at again until the word is through
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r      <= SPWF_IDLE;
      cnt_r     <= 4'h0;
      started_r <= 1'b0;
    end else if (fall_in) begin
      started_r <= req_in ? 1'b0 : (started_r | wstart_out);
      case (alt_in)
        1'b1: begin
          st_r  <= (bit_out && !last_out) ? SPWF_BUSY : SPWF_IDLE;
          cnt_r <= (bit_out && !last_out) ? idx_out + 4'h1 : 4'h0;
        end
        1'b0: begin
          if (wstart_out) begin
            st_r  <= SPWF_BUSY;
            cnt_r <= 4'h0;
          end else if (last_out) begin
            st_r  <= SPWF_IDLE;
            cnt_r <= 4'h0;
          end else if (!idle) begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        default: begin
          st_r  <= SPWF_IDLE;
          cnt_r <= 4'h0;
        end
      endcase
    end
  end

endmodule // spwf_frame_ctl
`default_nettype wire

// file: src/spwf_port.sv
// One synchronous serial port: word length and frame synchronisation.
// Assumes the core writes registers by data memory address and loads the
// transmit word through a strobe; link pins are asynchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module spwf_port
  import spwf_pkg::*;
#(
  parameter logic [13:0] CTL_ADDR  = SPWF_P0_CTL_ADDR,
  parameter logic [13:0] DIV_ADDR  = SPWF_P0_DIV_ADDR,
  parameter int          SCLK_HALF = SPWF_SCLK_HALF_DEF
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // Data memory register access
  input  wire logic [13:0] dm_addr_in,
  input  wire logic [15:0] dm_wdata_in,
  input  wire logic        dm_wr_in,
  input  wire logic        dm_rd_in,
  output logic      [15:0] dm_rdata_out,
  output logic             dm_rvalid_out,
  // Transmit and receive data registers
  input  wire logic        tx_load_in,
  input  wire logic [15:0] tx_wdata_in,
  output logic             tx_full_out,
  output logic      [15:0] rx_data_out,
  output logic             rx_irq_out,
  // Serial clock pin
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe_out,
  // Frame sync pins
  input  wire logic        rx_frame_pin_in,
  output logic             rx_frame_pin_out,
  output logic             rx_frame_pin_oe_out,
  input  wire logic        tx_frame_pin_in,
  output logic             tx_frame_pin_out,
  output logic             tx_frame_pin_oe_out,
  // Serial data pins
  input  wire logic        dr_in,
  output logic             dt_out,
  output logic             dt_oe_out
);

  // Keeps a word right-justified: bits above the word length read zero
  function automatic logic [15:0] spwf_len_mask(input logic [3:0] m1);
    spwf_len_mask = 16'hffff >> (4'hf - m1);
  endfunction

  localparam logic [15:0] HALF_M1 = 16'(SCLK_HALF - 1);

  logic [15:0] ctl_r;
  logic [15:0] rx_frame_divider_r;
  logic [3:0]  word_len_minus_one;
  logic        rx_frame_required;
  logic        tx_frame_required;
  logic        rx_frame_internal;
  logic        tx_frame_internal;
  logic        rx_frame_alt_mode;
  logic        tx_frame_alt_mode;
  logic        rx_frame_active_low;
  logic        tx_frame_active_low;
  logic        serial_clock_internal;

  // Control fields
  assign word_len_minus_one    = ctl_r[SPWF_LEN_MSB:SPWF_LEN_LSB];
  assign rx_frame_required     = ctl_r[SPWF_RX_REQ_BIT];
  assign tx_frame_required     = ctl_r[SPWF_TX_REQ_BIT];
  assign rx_frame_internal     = ctl_r[SPWF_RX_INT_BIT];
  assign tx_frame_internal     = ctl_r[SPWF_TX_INT_BIT];
  assign rx_frame_alt_mode     = ctl_r[SPWF_RX_ALT_BIT];
  assign tx_frame_alt_mode     = ctl_r[SPWF_TX_ALT_BIT];
  assign rx_frame_active_low   = ctl_r[SPWF_RX_POL_BIT];
  assign tx_frame_active_low   = ctl_r[SPWF_TX_POL_BIT];
  assign serial_clock_internal = ctl_r[SPWF_SCLK_INT_BIT];

  // Register writes; reserved and out-of-scope bits are stored for readback
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctl_r              <= SPWF_CTL_RST;
      rx_frame_divider_r <= SPWF_DIV_RST;
    end else if (dm_wr_in) begin
      if (dm_addr_in == CTL_ADDR) begin
        ctl_r <= dm_wdata_in;
      end
      if (dm_addr_in == DIV_ADDR) begin
        rx_frame_divider_r <= dm_wdata_in;
      end
    end
  end

  // Register reads, one cycle latency; other addresses answer zero
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dm_rdata_out  <= SPWF_DATA_RST;
      dm_rvalid_out <= 1'b0;
    end else begin
      dm_rvalid_out <= dm_rd_in;
      if (dm_rd_in && dm_addr_in == CTL_ADDR) begin
        dm_rdata_out <= ctl_r;
      end else if (dm_rd_in && dm_addr_in == DIV_ADDR) begin
        dm_rdata_out <= rx_frame_divider_r;
      end else begin
        dm_rdata_out <= SPWF_DATA_RST;
      end
    end
  end

  // Pin inputs pass two flops before any logic sees them
  logic [3:0] pins_s;
  spwf_sync2 #(
    .W (4)
  ) u_sync (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .async_in ({sclk_in, rx_frame_pin_in, tx_frame_pin_in, dr_in}),
    .sync_out (pins_s)
  );

  // Internal serial clock, free running while selected
  logic [15:0] sclk_div_r;
  logic        sclk_int_r;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_div_r  <= 16'h0000;
      sclk_int_r  <= 1'b0;
      sclk_out    <= 1'b0;
      sclk_oe_out <= 1'b0;
    end else begin
      sclk_oe_out <= serial_clock_internal;
      sclk_out    <= sclk_int_r;
      if (!serial_clock_internal) begin
        sclk_div_r <= 16'h0000;
      end else if (sclk_div_r == HALF_M1) begin
        sclk_div_r <= 16'h0000;
        sclk_int_r <= !sclk_int_r;
      end else begin
        sclk_div_r <= sclk_div_r + 16'h0001;
      end
    end
  end

  // Edge events of whichever serial clock is selected
  logic sclk_lvl;
  logic sclk_prev_r;
  logic fall;
  logic rise;
  assign sclk_lvl = serial_clock_internal ? sclk_int_r : pins_s[3];
  assign fall     = sclk_prev_r && !sclk_lvl;
  assign rise     = !sclk_prev_r && sclk_lvl;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= sclk_lvl;
    end
  end

  // Generated sync levels change on rises, so they meet the fall sampling
  logic rx_gen_r;
  logic tx_gen_r;
  logic rx_frame;
  logic tx_frame;
  assign rx_frame = rx_frame_internal ? rx_gen_r : (pins_s[2] ^ rx_frame_active_low);
  assign tx_frame = tx_frame_internal ? tx_gen_r : (pins_s[1] ^ tx_frame_active_low);

  // Receive sequencer
  logic       rx_bit;
  logic [3:0] rx_idx;
  logic       rx_last;
  spwf_frame_ctl u_rx_ctl (
    .clk_in     (clk_in),
    .nrst_in    (nrst_in),
    .fall_in    (fall),
    .frame_in   (rx_frame),
    .alt_in     (rx_frame_alt_mode),
    .req_in     (rx_frame_required),
    .len_m1_in  (word_len_minus_one),
    .bit_out    (rx_bit),
    .idx_out    (rx_idx),
    .last_out   (rx_last),
    .wstart_out (),
    .busy_out   (),
    .cnt_out    ()
  );

  // Transmit sequencer
  logic       tx_wstart;
  logic       tx_busy;
  logic [3:0] tx_cnt;
  spwf_frame_ctl u_tx_ctl (
    .clk_in     (clk_in),
    .nrst_in    (nrst_in),
    .fall_in    (fall),
    .frame_in   (tx_frame),
    .alt_in     (tx_frame_alt_mode),
    .req_in     (tx_frame_required),
    .len_m1_in  (word_len_minus_one),
    .bit_out    (),
    .idx_out    (),
    .last_out   (),
    .wstart_out (tx_wstart),
    .busy_out   (tx_busy),
    .cnt_out    (tx_cnt)
  );

  // Receive shifter; nothing is latched until a sync has started a word
  logic [15:0] rx_shift_r;
  logic [15:0] rx_word;
  assign rx_word = {rx_shift_r[14:0], pins_s[0]};
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_shift_r  <= SPWF_DATA_RST;
      rx_data_out <= SPWF_DATA_RST;
      rx_irq_out  <= 1'b0;
    end else begin
      rx_irq_out <= fall && rx_last;
      if (fall && rx_bit) begin
        rx_shift_r <= (rx_idx == 4'h0) ? {15'h0000, pins_s[0]} : rx_word;
        if (rx_last) begin
          rx_data_out <= rx_word & spwf_len_mask(word_len_minus_one);
        end
      end
    end
  end

  // Internal receive sync: every divider+1 serial clocks
  logic [15:0] rx_div_cnt_r;
  logic [3:0]  rx_hold_r;
  logic        rx_fire;
  assign rx_fire = (rx_div_cnt_r == 16'h0000);
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_div_cnt_r <= SPWF_DIV_RST;
      rx_hold_r    <= 4'h0;
      rx_gen_r     <= 1'b0;
    end else if (!rx_frame_internal) begin
      rx_div_cnt_r <= rx_frame_divider_r;
      rx_hold_r    <= 4'h0;
      rx_gen_r     <= 1'b0;
    end else if (rise) begin
      rx_div_cnt_r <= rx_fire ? rx_frame_divider_r : rx_div_cnt_r - 16'h0001;
      // Alternate framing widens the pulse to the word length
      if (rx_fire) begin
        rx_hold_r <= rx_frame_alt_mode ? word_len_minus_one : 4'h0;
      end else if (rx_hold_r != 4'h0) begin
        rx_hold_r <= rx_hold_r - 4'h1;
      end
      rx_gen_r <= rx_fire || (rx_hold_r != 4'h0);
    end
  end

  // Transmit holding register; a core load wins over the same-cycle take
  logic [15:0] tx_buf_r;
  logic [15:0] tx_shift_r;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_buf_r    <= SPWF_DATA_RST;
      tx_shift_r  <= SPWF_DATA_RST;
      tx_full_out <= 1'b0;
    end else begin
      if (fall && tx_wstart) begin
        tx_shift_r <= tx_buf_r;
      end
      if (tx_load_in) begin
        tx_buf_r    <= tx_wdata_in & 16'hffff;
        tx_full_out <= 1'b1;
      end else if (fall && tx_wstart) begin
        tx_full_out <= 1'b0;
      end
    end
  end

  // Internal transmit sync: normal only when data waits, on the last bit or idle; alternate while busy or data waits
  logic tx_last_next;
  assign tx_last_next = tx_busy && (tx_cnt == word_len_minus_one);
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_gen_r <= 1'b0;
    end else if (!tx_frame_internal) begin
      tx_gen_r <= 1'b0;
    end else if (rise) begin
      if (tx_frame_alt_mode) begin
        tx_gen_r <= tx_busy || tx_full_out;
      end else begin
        tx_gen_r <= tx_full_out && (!tx_busy || tx_last_next);
      end
    end
  end

  // Data out MSB first on rises; idle line pre-drives the next word's MSB
  logic [3:0] tx_pos;
  assign tx_pos = word_len_minus_one - tx_cnt;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dt_out    <= 1'b0;
      dt_oe_out <= 1'b0;
    end else if (rise) begin
      dt_out    <= tx_busy ? tx_shift_r[tx_pos] : tx_buf_r[word_len_minus_one];
      dt_oe_out <= tx_busy || tx_full_out;
    end
  end

  // Frame pins: output only when generated here, polarity applied
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_frame_pin_out    <= 1'b0;
      rx_frame_pin_oe_out <= 1'b0;
      tx_frame_pin_out    <= 1'b0;
      tx_frame_pin_oe_out <= 1'b0;
    end else begin
      rx_frame_pin_oe_out <= rx_frame_internal;
      tx_frame_pin_oe_out <= tx_frame_internal;
      rx_frame_pin_out    <= rx_gen_r ^ rx_frame_active_low;
      tx_frame_pin_out    <= tx_gen_r ^ tx_frame_active_low;
    end
  end

endmodule // spwf_port
`default_nettype wire

// file: verification/spwf_port_asserts.sv
// Checker for one serial port: register map, pin enables, word flags.
// Assumes a bind onto spwf_port; registers change only by bus writes.
`timescale 1ns/1ps
`default_nettype none
module spwf_port_asserts
  import spwf_pkg::*;
#(
  parameter logic [13:0] CTL_ADDR = SPWF_P0_CTL_ADDR,
  parameter logic [13:0] DIV_ADDR = SPWF_P0_DIV_ADDR
) (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        nrst_in,
  // Register bus
  input wire logic [13:0] dm_addr_in,
  input wire logic [15:0] dm_wdata_in,
  input wire logic        dm_wr_in,
  input wire logic        dm_rd_in,
  input wire logic [15:0] dm_rdata_out,
  input wire logic        dm_rvalid_out,
  // Data registers and pins
  input wire logic        tx_load_in,
  input wire logic        tx_full_out,
  input wire logic [15:0] rx_data_out,
  input wire logic        rx_irq_out,
  input wire logic        sclk_in,
  input wire logic        sclk_oe_out,
  input wire logic        rx_frame_pin_oe_out,
  input wire logic        tx_frame_pin_oe_out
);
  logic [15:0] ctl_r;
  logic [15:0] div_r;
  logic        sclk_r;
  logic [3:0]  quiet_r;
  logic        ctl_wr;
  logic        rd_map;

  // Decoded bus events
  assign ctl_wr = dm_wr_in && dm_addr_in == CTL_ADDR;
  assign rd_map = dm_addr_in == CTL_ADDR || dm_addr_in == DIV_ADDR;

  // Register shadow built from bus writes only
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctl_r <= SPWF_CTL_RST;
      div_r <= SPWF_DIV_RST;
    end else begin
      if (ctl_wr) ctl_r <= dm_wdata_in;
      if (dm_wr_in && dm_addr_in == DIV_ADDR) div_r <= dm_wdata_in;
    end
  end

  // Cycles since the clock pin moved; internal clock restarts the count
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_r  <= 1'b0;
      quiet_r <= 4'h0;
    end else begin
      sclk_r  <= sclk_in;
      quiet_r <= (sclk_oe_out || sclk_in != sclk_r) ? 4'h0 : ((quiet_r == 4'hf) ? quiet_r : quiet_r + 4'h1);
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  AST_CTL_READ: assert property (dm_rd_in && dm_addr_in == CTL_ADDR |=> dm_rvalid_out && dm_rdata_out == $past(ctl_r))
    else $error("control readback differs from last write");
  AST_DIV_READ: assert property (dm_rd_in && dm_addr_in == DIV_ADDR |=> dm_rdata_out == $past(div_r))
    else $error("divider readback differs from last write");
  AST_HOLE_READ: assert property (dm_rd_in && !rd_map |=> dm_rvalid_out && dm_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  AST_RX_SRC: assert property (rx_frame_pin_oe_out == $past(ctl_r[SPWF_RX_INT_BIT]))
    else $error("receive sync drive differs from source bit");
  AST_TX_SRC: assert property (ctl_wr |=> ##1 tx_frame_pin_oe_out == $past(dm_wdata_in[SPWF_TX_INT_BIT], 2))
    else $error("transmit sync drive differs from source bit");
  AST_SCLK_SRC: assert property ($rose(sclk_oe_out) |-> $past(ctl_wr && dm_wdata_in[SPWF_SCLK_INT_BIT], 2))
    else $error("clock drive rose without a write");
  AST_IRQ_PULSE: assert property (rx_irq_out |=> !rx_irq_out)
    else $error("receive interrupt longer than one cycle");
  AST_RX_RIGHT: assert property (rx_irq_out |-> (rx_data_out >> ({1'b0, ctl_r[3:0]} + 5'h01)) == 16'h0000)
    else $error("received word not right-justified");
  AST_TX_LOAD: assert property (tx_load_in |=> tx_full_out)
    else $error("load did not mark transmit full");
  AST_TX_WAIT: assert property (tx_full_out && quiet_r >= 4'h6 |=> tx_full_out)
    else $error("transmit word taken without a clock edge");
  AST_RX_WAIT: assert property (quiet_r >= 4'h8 |-> !rx_irq_out)
    else $error("word received without a clock edge");
endmodule // spwf_port_asserts

bind spwf_port spwf_port_asserts #(.CTL_ADDR(CTL_ADDR), .DIV_ADDR(DIV_ADDR)) u_chk (
  .clk_in, .nrst_in, .dm_addr_in, .dm_wdata_in, .dm_wr_in, .dm_rd_in, .dm_rdata_out, .dm_rvalid_out,
  .tx_load_in, .tx_full_out, .rx_data_out, .rx_irq_out, .sclk_in, .sclk_oe_out,
  .rx_frame_pin_oe_out, .tx_frame_pin_oe_out
);
`default_nettype wire

// file: verification/spwf_codec.sv
// Far-side serial device: clocks one framed word out, captures the reply.
// Assumes the core clock is much faster than its serial clock.
`timescale 1ns/1ps
`default_nettype none
module spwf_codec #(
  parameter int HALF = 6
) (
  // Clock and word request
  input  wire logic        clk_in,
  input  wire logic        send_in,
  input  wire logic [15:0] word_in,
  input  wire logic [4:0]  len_in,
  input  wire logic        inv_in,
  input  wire logic        dt_in,
  // Link pins and status
  output logic             sclk_out,
  output logic             fs_out,
  output logic             dr_out,
  output logic             busy_out,
  output logic      [15:0] cap_out
);
  logic act = 1'b0;

  // Polarity applied at the pin
  assign fs_out = act ^ inv_in;

  // Normal framing; clock stands low between words
  always begin
    @(posedge clk_in iff send_in);
    busy_out = 1'b1;
    cap_out = 16'h0000;
    for (int i = -1; i < int'(len_in); i++) begin
      #1;
      sclk_out = 1'b1;
      act = (i < 0);
      dr_out = (i < 0) ? ~dr_out : word_in[int'(len_in) - 1 - i];
      repeat (HALF) @(posedge clk_in);
      #1;
      if (i >= 0) cap_out = {cap_out[14:0], dt_in};
      sclk_out = 1'b0;
      repeat (HALF) @(posedge clk_in);
    end
    #1;
    act = 1'b0;
    dr_out = ~dr_out; // Inverted line, no longer the last bit
    busy_out = 1'b0;
  end

  // Idle levels
  initial begin
    sclk_out = 1'b0;
    dr_out = 1'b0;
    busy_out = 1'b0;
    cap_out = 16'h0000;
  end
endmodule // spwf_codec
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for one serial port facing a far-side word source.
// Assumes port0 addresses; the far side clocks words in from outside.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import spwf_pkg::*;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic [13:0] dm_addr_in = 14'h0000;
  logic [15:0] dm_wdata_in = 16'h0000;
  logic        dm_wr_in = 1'b0;
  logic        dm_rd_in = 1'b0;
  logic        tx_load_in = 1'b0;
  logic [15:0] tx_wdata_in = 16'h0000;
  logic        send = 1'b0;
  logic [15:0] cword = 16'h0000;
  logic [4:0]  clen = 5'h00;
  logic        cinv = 1'b0;
  logic [15:0] dm_rdata_out, rx_data_out, c_cap, rx_got;
  logic        dm_rvalid_out, tx_full_out, rx_irq_out, sclk_out, sclk_oe_out, dt_out, dt_oe_out;
  logic        rx_fs_out, rx_fs_oe, tx_fs_out, tx_fs_oe, c_sclk, c_fs, c_dr, c_busy;
  int          fails = 0;
  int          compares = 0;
  int          cyc = 0;
  int          irqs = 0;

  // Pin levels from whichever party drives them
  wire sclk_w  = sclk_oe_out ? sclk_out : c_sclk;
  wire rx_fs_w = rx_fs_oe ? rx_fs_out : c_fs;
  wire tx_fs_w = tx_fs_oe ? tx_fs_out : c_fs;

  always #5 clk_in = ~clk_in;

  spwf_port #(.SCLK_HALF(2)) dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .dm_addr_in(dm_addr_in), .dm_wdata_in(dm_wdata_in),
    .dm_wr_in(dm_wr_in), .dm_rd_in(dm_rd_in), .dm_rdata_out(dm_rdata_out), .dm_rvalid_out(dm_rvalid_out),
    .tx_load_in(tx_load_in), .tx_wdata_in(tx_wdata_in), .tx_full_out(tx_full_out),
    .rx_data_out(rx_data_out), .rx_irq_out(rx_irq_out), .sclk_in(sclk_w), .sclk_out(sclk_out),
    .sclk_oe_out(sclk_oe_out), .rx_frame_pin_in(rx_fs_w), .rx_frame_pin_out(rx_fs_out),
    .rx_frame_pin_oe_out(rx_fs_oe), .tx_frame_pin_in(tx_fs_w), .tx_frame_pin_out(tx_fs_out),
    .tx_frame_pin_oe_out(tx_fs_oe), .dr_in(c_dr), .dt_out(dt_out), .dt_oe_out(dt_oe_out));

  spwf_codec #(.HALF(6)) u_codec (
    .clk_in(clk_in), .send_in(send), .word_in(cword), .len_in(clen), .inv_in(cinv), .dt_in(dt_out),
    .sclk_out(c_sclk), .fs_out(c_fs), .dr_out(c_dr), .busy_out(c_busy), .cap_out(c_cap));

  // Cycle count, hang limit and received-word capture
  always @(posedge clk_in) begin
    cyc++;
    if (rx_irq_out === 1'b1) begin
      irqs++;
      rx_got = rx_data_out;
    end
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [13:0] a, input logic [15:0] d);
    @(posedge clk_in);
    #1;
    dm_addr_in = a;
    dm_wdata_in = d;
    dm_wr_in = 1'b1;
    @(posedge clk_in);
    #1;
    dm_wr_in = 1'b0;
  endtask

  task automatic rd(input logic [13:0] a, input logic [15:0] e, input string n);
    @(posedge clk_in);
    #1;
    dm_addr_in = a;
    dm_rd_in = 1'b1;
    @(posedge clk_in);
    #1;
    dm_rd_in = 1'b0;
    chk(n, e, dm_rdata_out);
  endtask

  task automatic do_reset;
    @(posedge clk_in);
    #1;
    nrst_in = 1'b0;
    repeat (16) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
  endtask

  // One word from the far side; returns once its clock stands still
  task automatic xfer(input logic [15:0] w, input logic [4:0] n);
    int k;
    k = 0;
    @(posedge clk_in);
    #1;
    cword = w;
    clen = n;
    send = 1'b1;
    @(posedge clk_in);
    #1;
    send = 1'b0;
    while (c_busy === 1'b1 && k < 2000) begin
      @(posedge clk_in);
      #1;
      k++;
    end
  endtask

  // Wait for the receive sync pin to move to level v
  task automatic edge_to(input logic v, output int t);
    int k;
    k = 0;
    while (rx_fs_w === v && k < 200) begin
      @(posedge clk_in);
      #1;
      k++;
    end
    while (rx_fs_w !== v && k < 400) begin
      @(posedge clk_in);
      #1;
      k++;
    end
    t = cyc;
  endtask

  task automatic t_regs;
    rd(SPWF_P0_CTL_ADDR, SPWF_CTL_RST, "ctl reset");
    rd(SPWF_P0_DIV_ADDR, SPWF_DIV_RST, "div reset");
    chk("drives", 16'h0000, {13'h0000, sclk_oe_out, rx_fs_oe, tx_fs_oe});
    wr(SPWF_P0_CTL_ADDR, 16'h7fcf);
    wr(SPWF_P1_CTL_ADDR, 16'hffff);
    rd(SPWF_P1_CTL_ADDR, 16'h0000, "unmapped");
    rd(SPWF_P0_CTL_ADDR, 16'h7fcf, "ctl");
    chk("drives", 16'h0007, {13'h0000, sclk_oe_out, rx_fs_oe, tx_fs_oe});
    wr(SPWF_P0_CTL_ADDR, 16'h000f); // Length field kept legal
    $display("test regs done");
  endtask

  // Framed receive at 3, 8 and 16 bit lengths, one active low
  task automatic t_rx;
    logic [4:0] n;
    int k;
    for (int i = 0; i < 3; i++) begin
      n = (i == 0) ? 5'h03 : ((i == 1) ? 5'h08 : 5'h10);
      cinv = (i == 1);
      wr(SPWF_P0_CTL_ADDR, 16'h2800 | {9'h000, cinv, 2'h0, 4'(n - 5'h01)});
      irqs = 0;
      k = 0;
      xfer(16'hb5e9, n);
      while (irqs == 0 && k < 40) begin
        @(posedge clk_in);
        #1;
        k++;
      end
      chk("rx word", 16'hb5e9 & 16'((32'h1 << n) - 1), rx_got);
      chk("rx irqs", 16'h0001, 16'(irqs));
    end
    cinv = 1'b0;
    $display("test rx done");
  endtask

  task automatic t_tx;
    wr(SPWF_P0_CTL_ADDR, 16'h0807);
    @(posedge clk_in);
    #1;
    tx_wdata_in = 16'h00a6;
    tx_load_in = 1'b1;
    @(posedge clk_in);
    #1;
    tx_load_in = 1'b0;
    repeat (40) @(posedge clk_in);
    chk("tx held", 16'h0001, {15'h0000, tx_full_out});
    xfer(16'h0000, 5'h08);
    chk("tx word", 16'h00a6, c_cap);
    chk("tx taken", 16'h0000, {15'h0000, tx_full_out});
    $display("test tx done");
  endtask

  // Internal clock, divider 7: a sync every 8 serial clocks of 4 cycles
  task automatic t_rxgen;
    int t0;
    int t1;
    int hi;
    wr(SPWF_P0_DIV_ADDR, 16'h0007); // Divider plus one equals length in the two 8-bit passes
    // Passes: active high, active low, alternate 4-bit words; transmit sync internal
    for (int p = 0; p < 3; p++) begin
      wr(SPWF_P0_CTL_ADDR, (p == 2) ? 16'h5303 : (16'h4307 | {9'h000, p[0], 6'h00}));
      edge_to(~p[0], t0);
      edge_to(~p[0], t0);
      edge_to(~p[0], t1);
      chk("rx sync period", 16'h0020, 16'(t1 - t0));
      hi = 0;
      repeat (32) begin
        if (rx_fs_w === 1'b1) hi++;
        @(posedge clk_in);
        #1;
      end
      chk("rx sync high", (p == 0) ? 16'h0004 : ((p == 1) ? 16'h001c : 16'h0010), 16'(hi));
      chk("rx sync drive", 16'h0001, {15'h0000, rx_fs_oe});
      chk("tx sync idle", 16'h0000, {15'h0000, tx_fs_w});
    end
    // A loaded word raises exactly one transmit sync, then runs unframed
    @(posedge clk_in);
    #1;
    tx_load_in = 1'b1;
    @(posedge clk_in);
    #1;
    tx_load_in = 1'b0;
    hi = 0;
    repeat (40) begin
      if (tx_fs_w === 1'b1) hi++;
      @(posedge clk_in);
      #1;
    end
    chk("tx sync high", 16'h0004, 16'(hi));
    chk("tx sync taken", 16'h0000, {15'h0000, tx_full_out});
    $display("test rx sync done");
  endtask

  task automatic finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Each test up to t_tx starts from reset so no half word is left over
  initial begin
    do_reset();
    t_regs();
    do_reset();
    t_rx();
    do_reset();
    t_tx();
    t_rxgen();
    finish_test();
  end
endmodule // testbench
`default_nettype wire
